// file: rtl/tdm_audio_serial_port.sv
// Two-port TDM serial audio engine (I2S, PCM, GCI) with APB registers
//----------------------------------------
`timescale 1ns/10ps
`default_nettype none
module tdm_audio_serial_port
	import tdm_pkg::*;
(
	// System
	input wire logic sys_clk,
	input wire logic srst,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Bit clock pins
	input wire logic [NPORT-1:0] bit_clock_in,
	output logic [NPORT-1:0] bit_clock_out,
	output logic [NPORT-1:0] bit_clock_oe,
	// Frame sync or word select pins
	input wire logic [NPORT-1:0] tdm_frame_sync_in,
	output logic [NPORT-1:0] tdm_frame_sync_out,
	output logic [NPORT-1:0] tdm_frame_sync_oe,
	// Serial data pins
	input wire logic [NPORT-1:0] tdm_serial_in,
	output logic [NPORT-1:0] tdm_serial_out,
	output logic [NPORT-1:0] tdm_serial_oe
);
	//----------------------------------------
	// Register storage
	//----------------------------------------
	port_cfg_t cfg_q [NPORT];
	logic [DIV_W-1:0] div_q [NPORT];
	ch_cfg_t ch_q [NPORT][NCH];
	logic [SAMPLE_W-1:0] tx_q [NPORT][NCH];
	logic [SAMPLE_W-1:0] rx_w [NPORT][NCH];
	logic [SAMPLE_W-1:0] stat_w [NPORT];
	logic [31:0] prdata_q;
	logic slverr_q;
	logic [31:0] rd_word;
	logic [31:0] wr_word;
	logic wr_en;
	reg_dec_t acc;

	//----------------------------------------
	// Cross-port timing shares
	//----------------------------------------
	logic share [NPORT];
	logic own_lvl [NPORT];
	logic own_rise [NPORT];
	logic own_fall [NPORT];
	logic own_start [NPORT];
	logic sdo_w [NPORT];

	//----------------------------------------
	// Functions
	//----------------------------------------
	function automatic reg_dec_t decode(input logic [7:0] a);
		reg_dec_t d;
		d.port = a[PORT_SEL_BIT];
		d.idx = a[IDX_MSB:IDX_LSB];
		d.kind = RK_NONE;
		if (!a[WIN_TOP_BIT] && a[IDX_LSB-1:0] == '0) begin
			case (a[5:0] & GRP_MASK)
				OFF_CH: d.kind = RK_CH;
				OFF_TX: d.kind = RK_TX;
				OFF_RX: d.kind = RK_RX;
				default: begin
					if (a[5:0] == OFF_CTRL) begin
						d.kind = RK_CTRL;
					end else if (a[5:0] == OFF_DIV) begin
						d.kind = RK_DIV;
					end else if (a[5:0] == OFF_STAT) begin
						d.kind = RK_STAT;
					end
				end
			endcase
		end
		return d;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Which sample bit, if any, a channel owns at a given frame bit
	function automatic bit_map_t map_bit(input port_cfg_t pc, input ch_cfg_t ch,
		input logic [BCNT_W-1:0] b);
		bit_map_t m;
		logic [BPF_W-1:0] bpf;
		logic [BPF_W-1:0] half;
		logic [BPF_W-1:0] pos;
		logic [BPF_W-1:0] rel;
		logic [BPF_W-1:0] rel2;
		logic [IDX_W-1:0] w;
		logic [IDX_W-1:0] k;
		logic side;
		logic inpair;
		logic word2;
		bpf = bpf_of(pc.bpf_code);
		half = bpf >> 1;
		w = (pc.enc == ENC_LIN16) ? W_WORD : W_BYTE;
		m = '0;
		k = '0;
		side = 1'b0;
		inpair = 1'b0;
		word2 = 1'b0;
		rel = '0;
		rel2 = '0;
		pos = BPF_W'(b);
		if (pc.framing == FR_I2S_STD || pc.framing == FR_I2S_LJ) begin
			if (pc.framing == FR_I2S_STD) begin
				pos = (b == '0) ? bpf - 1'b1 : pos - 1'b1;
			end
			side = pos >= half;
			if (side) begin
				pos = pos - half;
			end
			m.hit = ch.en && (ch.slot[0] == side) && (pos < BPF_W'(w));
			k = IDX_W'(pos);
		end else begin
			rel = BPF_W'(b >> SLOT_SH) - BPF_W'(ch.slot);
			rel2 = rel - (bpf >> HALF_SH);
			inpair = (pc.enc == ENC_LIN16) ? (rel < PAIR_SLOTS) : (rel == '0);
			if (inpair) begin
				k = IDX_W'({rel[0], b[SLOT_SH-1:0]});
			end else if (pc.half_frame_wideband_mode && pc.enc == ENC_LIN16 && rel2 < PAIR_SLOTS) begin
				word2 = 1'b1;
				k = IDX_W'({rel2[0], b[SLOT_SH-1:0]});
			end
			m.hit = ch.en && (inpair || word2);
		end
		m.idx = (pc.lsb_first ? k : w - 1'b1 - k) + (word2 ? HALF_OFS : '0);
		return m;
	endfunction

	//----------------------------------------
	// APB slave
	//----------------------------------------
	assign acc = decode(paddr);
	assign wr_en = psel && penable && pwrite;
	assign wr_word = merge(rd_word, pwdata, pstrb);

	always_comb begin
		rd_word = '0;
		unique case (acc.kind)
			RK_CTRL: rd_word = 32'(cfg_q[acc.port]);
			RK_DIV: rd_word = 32'(div_q[acc.port]);
			RK_STAT: rd_word = stat_w[acc.port];
			RK_CH: rd_word = 32'(ch_q[acc.port][acc.idx]);
			RK_TX: rd_word = tx_q[acc.port][acc.idx];
			RK_RX: rd_word = rx_w[acc.port][acc.idx];
			RK_NONE: rd_word = '0;
		endcase
	end

	// Status and receive words are read-only, writes to them are dropped
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int p = 0; p < NPORT; p++) begin
				cfg_q[p] <= CFG_RST;
				div_q[p] <= DIV_RST;
				for (int c = 0; c < NCH; c++) begin
					ch_q[p][c] <= CH_RST;
					tx_q[p][c] <= '0;
				end
			end
		end else if (wr_en) begin
			unique case (acc.kind)
				RK_CTRL: cfg_q[acc.port] <= port_cfg_t'(wr_word[$bits(port_cfg_t)-1:0]);
				RK_DIV: div_q[acc.port] <= wr_word[DIV_W-1:0];
				RK_CH: ch_q[acc.port][acc.idx] <= ch_cfg_t'(wr_word[$bits(ch_cfg_t)-1:0]);
				RK_TX: tx_q[acc.port][acc.idx] <= wr_word;
				RK_STAT, RK_RX, RK_NONE: ;
			endcase
		end
	end

	// Read data is captured in the setup phase so it comes from a register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prdata_q <= '0;
			slverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q <= pwrite ? '0 : rd_word;
			slverr_q <= acc.kind == RK_NONE;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = slverr_q;

	//----------------------------------------
	// Timing shares between ports
	//----------------------------------------
	assign share[0] = 1'b0;
	assign share[1] = cfg_q[1].master && (cfg_q[0].master || cfg_q[1].sync_follow);

	//----------------------------------------
	// Port engines
	//----------------------------------------
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		port_cfg_t pc;
		logic clk_lvl;
		logic clk_rise;
		logic clk_fall;
		logic sync_lvl;
		logic din_lvl;
		logic gen_lvl;
		logic gen_rise;
		logic gen_fall;
		logic rise;
		logic fall;
		logic drv;
		logic smp;
		logic is_i2s;
		logic left_lvl;
		logic sync_seen;
		logic start;
		logic din;
		logic tx_hit;
		logic tx_bit;
		logic [BPF_W-1:0] bpf;
		logic [BCNT_W-1:0] nxt;
		logic [BCNT_W-1:0] bit_q;
		logic [FCNT_W-1:0] frame_q;
		logic sync_prev_q;
		logic sync_out_q;
		logic dout_q;
		logic oe_q;
		bit_map_t tx_map [NCH];
		bit_map_t rx_map [NCH];

		assign pc = cfg_q[p];

		link_sync u_clk_sync (
			.sys_clk(sys_clk),
			.srst(srst),
			.async_in(bit_clock_in[p]),
			.level(clk_lvl),
			.rise(clk_rise),
			.fall(clk_fall)
		);

		link_sync u_sync_sync (
			.sys_clk(sys_clk),
			.srst(srst),
			.async_in(tdm_frame_sync_in[p]),
			.level(sync_lvl),
			.rise(),
			.fall()
		);

		link_sync u_din_sync (
			.sys_clk(sys_clk),
			.srst(srst),
			.async_in(tdm_serial_in[p]),
			.level(din_lvl),
			.rise(),
			.fall()
		);

		bit_clock_div u_div (
			.sys_clk(sys_clk),
			.srst(srst),
			.run(pc.enable && pc.master),
			.half_period(div_q[p]),
			.level(gen_lvl),
			.rise(gen_rise),
			.fall(gen_fall)
		);

		// Bit clock source: own divider as master, recovered pin as slave
		assign own_lvl[p] = pc.master ? gen_lvl : clk_lvl;
		assign own_rise[p] = pc.enable && (pc.master ? gen_rise : clk_rise);
		assign own_fall[p] = pc.enable && (pc.master ? gen_fall : clk_fall);
		assign rise = pc.enable && (share[p] ? own_rise[0] : own_rise[p]);
		assign fall = pc.enable && (share[p] ? own_fall[0] : own_fall[p]);

		assign is_i2s = pc.framing == FR_I2S_STD || pc.framing == FR_I2S_LJ;
		assign drv = (pc.framing == FR_PCM && pc.transmit_edge_select) ? rise : fall;
		assign smp = (pc.framing == FR_PCM && pc.transmit_edge_select) ? fall : rise;
		assign bpf = bpf_of(pc.bpf_code);
		assign nxt = (BPF_W'(bit_q) == bpf - 1'b1) ? '0 : bit_q + 1'b1;

		// Frame start is judged mid-bit, so any slave pulse width works
		assign sync_seen = pc.master ? sync_out_q : sync_lvl;
		assign left_lvl = pc.framing == FR_I2S_LJ;
		assign own_start[p] = smp && (is_i2s ? (sync_seen == left_lvl && sync_prev_q != left_lvl)
			: (sync_seen && !sync_prev_q));
		assign start = share[p] ? own_start[0] : own_start[p];

		always_ff @(posedge sys_clk) begin
			if (srst || !pc.enable) begin
				sync_prev_q <= 1'b0;
			end else if (smp) begin
				sync_prev_q <= sync_seen;
			end
		end

		// Frame bit counter, realigned by every detected frame start
		always_ff @(posedge sys_clk) begin
			if (srst || !pc.enable || start) begin
				bit_q <= '0;
			end else if (drv) begin
				bit_q <= nxt;
			end
		end

		always_ff @(posedge sys_clk) begin
			if (srst) begin
				frame_q <= '0;
			end else if (start) begin
				frame_q <= frame_q + 1'b1;
			end
		end

		// Master sync: half-frame word select or one-bit pulse at bit zero
		always_ff @(posedge sys_clk) begin
			if (srst || !pc.enable) begin
				sync_out_q <= 1'b0;
			end else if (drv) begin
				if (is_i2s) begin
					sync_out_q <= (BPF_W'(nxt) >= (bpf >> 1)) ^ left_lvl;
				end else begin
					sync_out_q <= nxt == '0;
				end
			end
		end

		// Transmit: lowest-numbered channel wins if slots overlap
		always_comb begin
			tx_hit = 1'b0;
			tx_bit = 1'b0;
			for (int i = NCH - 1; i >= 0; i--) begin
				if (tx_map[i].hit) begin
					tx_hit = 1'b1;
					tx_bit = tx_q[p][i][tx_map[i].idx];
				end
			end
		end

		always_ff @(posedge sys_clk) begin
			if (srst || !pc.enable) begin
				dout_q <= 1'b0;
				oe_q <= 1'b0;
			end else if (drv) begin
				dout_q <= tx_bit;
				oe_q <= tx_hit;
			end
		end

		assign sdo_w[p] = dout_q;
		assign din = pc.loop_local ? dout_q : (pc.loop_cross ? sdo_w[NPORT-1-p] : din_lvl);

		// Receive words are written bit by bit, software may see a partial word
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			logic [SAMPLE_W-1:0] rx_q;
			assign tx_map[i] = map_bit(pc, ch_q[p][i], nxt);
			assign rx_map[i] = map_bit(pc, ch_q[p][i], bit_q);
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					rx_q <= '0;
				end else if (smp && rx_map[i].hit) begin
					rx_q[rx_map[i].idx] <= din;
				end
			end
			assign rx_w[p][i] = rx_q;
		end

		assign stat_w[p] = SAMPLE_W'({bit_q, frame_q});
		assign bit_clock_out[p] = share[p] ? own_lvl[0] : gen_lvl;
		assign bit_clock_oe[p] = pc.enable && pc.master;
		assign tdm_frame_sync_out[p] = sync_out_q;
		assign tdm_frame_sync_oe[p] = pc.enable && pc.master;
		assign tdm_serial_out[p] = dout_q;
		assign tdm_serial_oe[p] = oe_q;
	end
endmodule
`default_nettype wire

// file: rtl/tdm_pkg.sv
// Constants and types shared by the two-port serial audio block
package tdm_pkg;
	localparam int NPORT = 2;
	localparam int NCH = 4;
	localparam int BCNT_W = 10;
	localparam int BPF_W = 11;
	localparam int DIV_W = 16;
	localparam int SLOT_W = 8;
	localparam int SAMPLE_W = 32;
	localparam int IDX_W = 5;
	localparam int FCNT_W = 16;
	localparam int SLOT_SH = 3;
	localparam int HALF_SH = 4;
	//----------------------------------------
	// Register map, one window per port
	//----------------------------------------
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_DIV = 6'h04;
	localparam logic [5:0] OFF_STAT = 6'h08;
	localparam logic [5:0] OFF_CH = 6'h10;
	localparam logic [5:0] OFF_TX = 6'h20;
	localparam logic [5:0] OFF_RX = 6'h30;
	localparam logic [5:0] GRP_MASK = 6'h30;
	localparam int PORT_SEL_BIT = 6;
	localparam int WIN_TOP_BIT = 7;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 3;
	localparam logic [DIV_W-1:0] DIV_RST = 16'h0010;
	//----------------------------------------
	// Sample layout
	//----------------------------------------
	localparam logic [IDX_W-1:0] W_BYTE = 5'h08;
	localparam logic [IDX_W-1:0] W_WORD = 5'h10;
	localparam logic [IDX_W-1:0] HALF_OFS = 5'h10;
	localparam logic [BPF_W-1:0] PAIR_SLOTS = 11'h002;
	//----------------------------------------
	// Types
	//----------------------------------------
	typedef enum logic [1:0] {FR_I2S_STD, FR_I2S_LJ, FR_PCM, FR_GCI} framing_t;
	typedef enum logic [1:0] {ENC_G711, ENC_LIN16, ENC_G722} encoding_t;
	typedef enum logic [2:0] {RK_NONE, RK_CTRL, RK_DIV, RK_STAT, RK_CH, RK_TX, RK_RX} reg_kind_t;
	typedef struct packed {
		logic sync_follow;
		logic loop_cross;
		logic loop_local;
		logic half_frame_wideband_mode;
		logic transmit_edge_select;
		logic lsb_first;
		encoding_t enc;
		logic [3:0] bpf_code;
		framing_t framing;
		logic master;
		logic enable;
	} port_cfg_t;
	typedef struct packed {
		logic en;
		logic [SLOT_W-1:0] slot;
	} ch_cfg_t;
	typedef struct packed {
		logic hit;
		logic [IDX_W-1:0] idx;
	} bit_map_t;
	typedef struct packed {
		reg_kind_t kind;
		logic port;
		logic [1:0] idx;
	} reg_dec_t;
	localparam port_cfg_t CFG_RST = '0;
	localparam ch_cfg_t CH_RST = '0;
	function automatic logic [BPF_W-1:0] bpf_of(input logic [3:0] code);
		case (code)
			4'h0: return 11'h008;
			4'h1: return 11'h010;
			4'h2: return 11'h020;
			4'h3: return 11'h040;
			4'h4: return 11'h060;
			4'h5: return 11'h080;
			4'h6: return 11'h0C0;
			4'h7: return 11'h100;
			4'h8: return 11'h180;
			4'h9: return 11'h200;
			4'hA: return 11'h400;
			default: return 11'h040;
		endcase
	endfunction
endpackage

// file: rtl/link_sync.sv
// Three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none
module link_sync (
	// System
	input wire logic sys_clk,
	input wire logic srst,
	// Pin from outside the clock domain
	input wire logic async_in,
	// Filtered level and one-cycle edge pulses
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;
	logic rise_q;
	logic fall_q;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Only stages two and three vote, the first may be metastable
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			level_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			rise_q <= (s2_q == s3_q) && s3_q && !level_q;
			fall_q <= (s2_q == s3_q) && !s3_q && level_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end

	assign level = level_q;
	assign rise = rise_q;
	assign fall = fall_q;
endmodule
`default_nettype wire

// file: rtl/bit_clock_div.sv
// Bit clock generator for master ports, level plus edge enables
`timescale 1ns/10ps
`default_nettype none
module bit_clock_div
	import tdm_pkg::*;
(
	// System
	input wire logic sys_clk,
	input wire logic srst,
	// Control
	input wire logic run,
	input wire logic [DIV_W-1:0] half_period,
	// Generated clock and edge pulses
	output logic level,
	output logic rise,
	output logic fall
);
	logic [DIV_W-1:0] cnt_q;
	logic level_q;
	logic rise_q;
	logic fall_q;
	logic tick;

	// A zero divisor behaves as one so the clock never stalls
	assign tick = run && (half_period == '0 || cnt_q >= half_period - 1'b1);

	always_ff @(posedge sys_clk) begin
		if (srst || !run || tick) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || !run) begin
			level_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			rise_q <= tick && !level_q;
			fall_q <= tick && level_q;
			if (tick) begin
				level_q <= !level_q;
			end
		end
	end

	assign level = level_q;
	assign rise = rise_q;
	assign fall = fall_q;
endmodule
`default_nettype wire

// file: test/tdm_audio_serial_port_chk.sv
// Port-level assertions for the serial audio block
`timescale 1ns/10ps
`default_nettype none
module tdm_audio_serial_port_chk
	import tdm_pkg::*;
(
	// System
	input wire logic sys_clk,
	input wire logic srst,
	// APB
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	// Pins
	input wire logic [NPORT-1:0] bit_clock_out,
	input wire logic [NPORT-1:0] bit_clock_oe,
	input wire logic [NPORT-1:0] tdm_frame_sync_out,
	input wire logic [NPORT-1:0] tdm_frame_sync_oe,
	input wire logic [NPORT-1:0] tdm_serial_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	//----------------------------------------
	// Port 0 control shadow and pin history
	//----------------------------------------
	logic [3:0] ctl_q;
	logic bclk_q, ws_q, pcm_m, i2s_m, tgl;
	logic [3:0] rise_q;
	logic [15:0] hc_q, last_q;
	logic [1:0] nt_q;
	assign pcm_m = ctl_q[1:0] == 2'h3 && ctl_q[3];
	assign i2s_m = ctl_q[1:0] == 2'h3 && !ctl_q[3];
	assign tgl = tdm_frame_sync_out[0] != ws_q;
	always_ff @(posedge sys_clk) begin
		if (srst)
			ctl_q <= 4'h0;
		else if (psel && penable && pwrite && paddr == 8'h00)
			ctl_q <= pwdata[3:0];
	end
	// Bit clock rises while sync is high
	always_ff @(posedge sys_clk) begin
		bclk_q <= bit_clock_out[0];
		if (!tdm_frame_sync_out[0])
			rise_q <= 4'h0;
		else if (bit_clock_out[0] && !bclk_q)
			rise_q <= rise_q + 4'h1;
	end
	// Level lengths; the first two after enable may be partial, so skipped
	always_ff @(posedge sys_clk) begin
		ws_q <= tdm_frame_sync_out[0];
		hc_q <= tgl ? 16'h0001 : hc_q + 16'h0001;
		if (tgl)
			last_q <= hc_q;
		if (!i2s_m)
			nt_q <= 2'h0;
		else if (tgl && nt_q != 2'h3)
			nt_q <= nt_q + 2'h1;
	end
	//----------------------------------------
	// Assertions
	//----------------------------------------
	chk_reset_quiet: assert property (disable iff (1'b0)
		srst |=> bit_clock_oe == 2'b00 && tdm_frame_sync_oe == 2'b00 && tdm_serial_oe == 2'b00)
		else $error("pins driven after reset");
	chk_oe_pair: assert property (
		bit_clock_oe == tdm_frame_sync_oe)
		else $error("clock and sync enables differ");
	chk_same_clock: assert property (
		bit_clock_oe == 2'b11 && $past(bit_clock_oe, 2) == 2'b11 |-> bit_clock_out[0] == bit_clock_out[1])
		else $error("master bit clocks differ");
	chk_sync_width: assert property (
		$fell(tdm_frame_sync_out[0]) && pcm_m |-> rise_q == 4'h1)
		else $error("master sync not one bit wide");
	chk_ws_half: assert property (
		i2s_m && nt_q == 2'h3 && tgl |-> hc_q == last_q)
		else $error("word select duty not even");
	chk_slave_idle: assert property (
		ctl_q[1:0] == 2'h1 && $past(ctl_q, 2) == ctl_q |-> bit_clock_oe[0] == 1'b0 && tdm_frame_sync_oe[0] == 1'b0)
		else $error("slave drives clock or sync");
	chk_master_drives: assert property (
		ctl_q[1:0] == 2'h3 && $past(ctl_q, 2) == ctl_q |-> bit_clock_oe[0] && tdm_frame_sync_oe[0])
		else $error("master not driving clock and sync");
	chk_idle_release: assert property (
		!ctl_q[0] && $past(ctl_q, 2) == ctl_q |-> tdm_serial_oe[0] == 1'b0)
		else $error("disabled port drives data");
endmodule
bind tdm_audio_serial_port tdm_audio_serial_port_chk u_chk (
	.sys_clk(sys_clk),
	.srst(srst),
	.paddr(paddr),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pwdata(pwdata),
	.bit_clock_out(bit_clock_out),
	.bit_clock_oe(bit_clock_oe),
	.tdm_frame_sync_out(tdm_frame_sync_out),
	.tdm_frame_sync_oe(tdm_frame_sync_oe),
	.tdm_serial_oe(tdm_serial_oe)
);
`default_nettype wire

// file: test/tdm_codec_model.sv
// External codec model that owns bit clock and frame sync
`timescale 1ns/10ps
`default_nettype none
module tdm_codec_model (
	// Control
	input wire logic run,
	input wire logic [7:0] sync_w,
	input wire logic [31:0] pat,
	// Line from the block
	input wire logic line_in,
	// Pins to the block
	output logic bclk,
	output logic fsync,
	output logic sdo,
	// First 32 bits heard in the last frame
	output logic [31:0] cap
);
	localparam int BPF = 64;
	initial begin
		bclk = 1'b1;
		fsync = 1'b0;
		sdo = 1'b0;
		cap = 32'h0;
	end
	// Clock stands still between runs; a frame is never cut short
	always begin
		wait (run);
		for (int i = 0; i < BPF; i++) begin
			if (i > 0 && i <= 32)
				cap[32-i] = line_in;
			bclk = 1'b0;
			fsync = i < sync_w;
			sdo = (i < 32) ? pat[31-i] : ~sdo;
			#62.5;
			bclk = 1'b1;
			#62.5;
		end
	end
endmodule
`default_nettype wire

// file: test/test_tdm_audio_serial_port.sv
// Self-checking bench for the two-port serial audio block
`timescale 1ns/10ps
`default_nettype none
module test_tdm_audio_serial_port;
	import tdm_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic rel_q = 1'b0;
	logic run = 1'b0;
	logic [7:0] sync_w = 8'h01;
	logic [31:0] pat = 32'h0;
	logic [31:0] prdata, tx, ex, m, cap;
	logic pready, pslverr, c_bclk, c_fs, c_sd, lsb;
	logic [1:0] bco, bcoe, fso, fsoe, sdo, sdoe, bci, fsi, enc;
	logic [64:0] note;
	logic [64:0] notes[$];
	int err_count = 0;
	int n_tests = 0;
	integer seed = 1;
	always #5 sys_clk = ~sys_clk;
	// Released line shows a changing pattern, never a stale level
	always @(posedge sys_clk) rel_q <= ~rel_q;
	// Both slave clock inputs fed from one source
	assign bci = {bcoe[1] ? bco[1] : c_bclk, bcoe[0] ? bco[0] : c_bclk};
	assign fsi = {fsoe[1] ? fso[1] : c_fs, fsoe[0] ? fso[0] : c_fs};
	tdm_audio_serial_port dut (
		.sys_clk(sys_clk),
		.srst(srst),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.bit_clock_in(bci),
		.bit_clock_out(bco),
		.bit_clock_oe(bcoe),
		.tdm_frame_sync_in(fsi),
		.tdm_frame_sync_out(fso),
		.tdm_frame_sync_oe(fsoe),
		.tdm_serial_in({c_sd, c_sd}),
		.tdm_serial_out(sdo),
		.tdm_serial_oe(sdoe)
	);
	tdm_codec_model codec (
		.run(run),
		.sync_w(sync_w),
		.pat(pat),
		.line_in(sdoe[0] ? sdo[0] : rel_q),
		.bclk(c_bclk),
		.fsync(c_fs),
		.sdo(c_sd),
		.cap(cap)
	);
	//----------------------------------------
	// Tasks
	//----------------------------------------
	function automatic logic [15:0] rev16(input logic [15:0] v);
		for (int i = 0; i < 16; i++)
			rev16[i] = v[15-i];
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e, input logic er);
		notes.push_back({er, k, e});
		apb(a, 1'b0, 32'h0);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Read results against the oldest note
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
			note = notes.pop_front();
			cmp(prdata & note[63:32], note[31:0] & note[63:32]);
			cmp({31'h0, pslverr}, {31'h0, note[64]});
		end
	end
	initial begin
		#400000;
		err_count++;
		final_report();
	end
	//----------------------------------------
	// Scenarios
	//----------------------------------------
	initial begin
		repeat (10) @(posedge sys_clk);
		srst <= 1'b0;
		for (int p = 0; p < 2; p++) begin
			rd({1'b0, p[0], OFF_CTRL}, '1, 32'h0, 1'b0);
			rd({1'b0, p[0], OFF_DIV}, '1, {16'h0, DIV_RST}, 1'b0);
		end
		rd(8'h80, '1, 32'h0, 1'b1);
		apb(8'h08, 1'b1, '1);
		rd(8'h08, '1, 32'h0, 1'b0);
		for (int c = 0; c < 4; c++) begin
			tx = $random(seed) & 32'h1FF;
			apb({2'b01, OFF_CH | 6'(c << 2)}, 1'b1, tx);
			rd({2'b01, OFF_CH | 6'(c << 2)}, '1, tx, 1'b0);
		end
		$display("registers done");
		// Master in every framing, data looped back inside the port
		apb(8'h04, 1'b1, 32'h2);
		apb(8'h10, 1'b1, 32'h100);
		for (int f = 0; f < 4; f++) begin
			tx = $random(seed);
			apb(8'h20, 1'b1, tx);
			// PCM pass also runs half-frame wideband, second pair in the upper half word
			apb(8'h00, 1'b1, 32'h2133 | (f << 2) | ((f == 2) ? 32'h1000 : 32'h0));
			repeat (800) @(posedge sys_clk);
			apb(8'h00, 1'b1, 32'h0);
			rd(8'h30, (f == 2) ? 32'hFFFFFFFF : 32'h0000FFFF, tx, 1'b0);
			$display("master framing %0d done", f);
		end
		apb(8'h00, 1'b1, 32'h13B);
		apb(8'h40, 1'b1, 32'h13B);
		repeat (600) @(posedge sys_clk);
		apb(8'h00, 1'b1, 32'h0);
		apb(8'h40, 1'b1, 32'h0);
		$display("dual master done");
		// Slave PCM against the codec; slot 1 keeps the first slot free
		apb(8'h10, 1'b1, 32'h101);
		for (int k = 0; k < 4; k++) begin
			enc = (k == 2) ? 2'h0 : (k == 3) ? 2'h2 : 2'h1;
			lsb = (k == 1);
			tx = $random(seed);
			pat = $random(seed);
			sync_w = 8'(k + 1);
			apb(8'h20, 1'b1, tx);
			apb(8'h00, 1'b1, 32'h39 | {enc, 8'h00} | {lsb, 10'h000});
			run = 1'b1;
			repeat (2400) @(posedge sys_clk);
			run = 1'b0;
			repeat (1000) @(posedge sys_clk);
			apb(8'h00, 1'b1, 32'h0);
			ex = lsb ? {16'h0, rev16(pat[23:8])} : {16'h0, pat[23:8]};
			if (enc != 2'h1)
				ex = ex >> 8;
			m = (enc == 2'h1) ? 32'hFFFF : 32'hFF;
			rd(8'h30, m, ex, 1'b0);
			ex = lsb ? {8'h0, rev16(tx[15:0]), 8'h0} : {8'h0, tx[15:0], 8'h0};
			if (enc != 2'h1)
				ex = {8'h0, tx[7:0], 16'h0};
			m = (enc == 2'h1) ? 32'h00FFFF00 : 32'h00FF0000;
			cmp(cap & m, ex & m);
			$display("slave case %0d done", k);
		end
		for (int i = 0; i < 100 && notes.size() > 0; i++)
			@(posedge sys_clk);
		// A read that never completed leaves its note behind
		if (notes.size() > 0) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, notes.size(), 0);
		end
		final_report();
	end
endmodule
`default_nettype wire
